/* rtl/peripheral_module_disable.sv */
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "periph_disable_map.svh"

module peripheral_module_disable
  import periph_disable_pkg::*;
#(
  parameter bit HAS_MOTOR = 1'b1,
  parameter bit HAS_CAN   = 1'b1
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  // Register port
  input  wire periph_disable_pkg::reg_addr_t reg_addr,
  input  wire periph_disable_pkg::reg_word_t reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output periph_disable_pkg::reg_word_t      reg_rdata,
  // Peripheral disable lines
  output logic                               timer_a_off,
  output logic                               timer_b_off,
  output logic                               timer_c_off,
  output logic                               timer_d_off,
  output logic                               timer_e_off,
  output logic                               encoder_iface_off,
  output logic                               motor_pwm_off,
  output logic                               two_wire_port_off,
  output logic                               serial_port_b_off,
  output logic                               serial_port_a_off,
  output logic                               sync_serial_b_off,
  output logic                               sync_serial_a_off,
  output logic                               can_ctrl_off,
  output logic                               adc_off
);
  import periph_disable_pkg::*;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  localparam reg_word_t IMPL_MASK = `BASE_MASK
                                  | (HAS_MOTOR ? `MOTOR_MASK : 16'h0000)
                                  | (HAS_CAN ? `CAN_MASK : 16'h0000);

  function automatic logic hit(input reg_addr_t a);
    hit = (a == `PDC1_ADDR);
  endfunction

  wire logic      wr_hit;
  wire logic      rd_hit;
  reg_word_t      ctrl_q;
  reg_word_t      rdata_next;

  assign wr_hit     = reg_wr & hit(reg_addr);
  assign rd_hit     = reg_rd & hit(reg_addr);
  // Unmapped reads answer zero
  assign rdata_next = rd_hit ? ctrl_q : 16'h0000;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  disable_mask_reg #(
    .IMPL_MASK (IMPL_MASK)
  ) u_ctrl (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (wr_hit),
    .din      (reg_wdata),
    .q        (ctrl_q)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Disable lines are re-registered from the stored bits, so they lag the write by two cycles
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // Re-registered from the stored word: outputs come from flip-flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      {timer_e_off, timer_d_off, timer_c_off, timer_b_off, timer_a_off} <= 5'h00;
      {encoder_iface_off, motor_pwm_off, two_wire_port_off}             <= 3'h0;
      {serial_port_b_off, serial_port_a_off}                            <= 2'h0;
      {sync_serial_b_off, sync_serial_a_off, can_ctrl_off, adc_off}     <= 4'h0;
    end else begin
      timer_e_off       <= ctrl_q[`BIT_TIMER_E];
      timer_d_off       <= ctrl_q[`BIT_TIMER_D];
      timer_c_off       <= ctrl_q[`BIT_TIMER_C];
      timer_b_off       <= ctrl_q[`BIT_TIMER_B];
      timer_a_off       <= ctrl_q[`BIT_TIMER_A];
      encoder_iface_off <= ctrl_q[`BIT_ENCODER];
      motor_pwm_off     <= ctrl_q[`BIT_MOTOR_PWM];
      two_wire_port_off <= ctrl_q[`BIT_TWO_WIRE];
      serial_port_b_off <= ctrl_q[`BIT_SERIAL_B];
      serial_port_a_off <= ctrl_q[`BIT_SERIAL_A];
      sync_serial_b_off <= ctrl_q[`BIT_SYNC_B];
      sync_serial_a_off <= ctrl_q[`BIT_SYNC_A];
      can_ctrl_off      <= ctrl_q[`BIT_CAN];
      adc_off           <= ctrl_q[`BIT_ADC];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_timer_off_follow: assert property (wr_hit ##2 1 |-> timer_e_off == $past(reg_wdata[15], 2))
    else $error("timer e disable line wrong");
  a_disable_level: assert property (##1 adc_off == $past(ctrl_q[0]))
    else $error("adc disable line does not track bit");
  a_serial_bits: assert property (wr_hit |=> ctrl_q[6:5] == $past(reg_wdata[6:5]))
    else $error("serial port bits not stored");
  a_unimpl_zero: assert property (rd_hit |=> reg_rdata[8] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("unimplemented bit reads nonzero");
  a_variant_mask: assert property (ctrl_q[10:9] == 2'b00 || HAS_MOTOR)
    else $error("motor bits present without motor variant");
  a_can_mask: assert property (ctrl_q[1] == 1'b0 || HAS_CAN)
    else $error("can bit present without can variant");
  a_reset_clear: assert property (@(posedge core_clk) $past(srst) |-> ctrl_q == 16'h0000)
    else $error("register not cleared by reset");
  a_read_value: assert property (rd_hit |=> reg_rdata == $past(ctrl_q))
    else $error("read data wrong");

  // ----------------------------------------
  // Per-line tracking
  // ----------------------------------------
  // Each disable line shows its stored bit one cycle later
  a_timer_e_line: assert property (##1 timer_e_off == $past(ctrl_q[`BIT_TIMER_E]))
    else $error("timer e disable line does not track bit");
  a_timer_d_line: assert property (##1 timer_d_off == $past(ctrl_q[`BIT_TIMER_D]))
    else $error("timer d disable line does not track bit");
  a_timer_c_line: assert property (##1 timer_c_off == $past(ctrl_q[`BIT_TIMER_C]))
    else $error("timer c disable line does not track bit");
  a_timer_b_line: assert property (##1 timer_b_off == $past(ctrl_q[`BIT_TIMER_B]))
    else $error("timer b disable line does not track bit");
  a_timer_a_line: assert property (##1 timer_a_off == $past(ctrl_q[`BIT_TIMER_A]))
    else $error("timer a disable line does not track bit");
  a_encoder_line: assert property (##1 encoder_iface_off == $past(ctrl_q[`BIT_ENCODER]))
    else $error("encoder disable line does not track bit");
  a_motor_pwm_line: assert property (##1 motor_pwm_off == $past(ctrl_q[`BIT_MOTOR_PWM]))
    else $error("motor pwm disable line does not track bit");
  a_two_wire_line: assert property (##1 two_wire_port_off == $past(ctrl_q[`BIT_TWO_WIRE]))
    else $error("two wire disable line does not track bit");
  a_serial_b_line: assert property (##1 serial_port_b_off == $past(ctrl_q[`BIT_SERIAL_B]))
    else $error("serial b disable line does not track bit");
  a_serial_a_line: assert property (##1 serial_port_a_off == $past(ctrl_q[`BIT_SERIAL_A]))
    else $error("serial a disable line does not track bit");
  a_sync_b_line: assert property (##1 sync_serial_b_off == $past(ctrl_q[`BIT_SYNC_B]))
    else $error("sync serial b disable line does not track bit");
  a_sync_a_line: assert property (##1 sync_serial_a_off == $past(ctrl_q[`BIT_SYNC_A]))
    else $error("sync serial a disable line does not track bit");
  a_can_line: assert property (##1 can_ctrl_off == $past(ctrl_q[`BIT_CAN]))
    else $error("can disable line does not track bit");

  // ----------------------------------------
  // Storage, read and reset checks
  // ----------------------------------------
  // Any line high; a reset must leave none
  wire logic      any_off;

  assign any_off = timer_a_off | timer_b_off | timer_c_off | timer_d_off | timer_e_off
                 | encoder_iface_off | motor_pwm_off | two_wire_port_off
                 | serial_port_b_off | serial_port_a_off | sync_serial_b_off
                 | sync_serial_a_off | can_ctrl_off | adc_off;

  a_timer_bits_kept: assert property (wr_hit |=>
    ctrl_q[`BIT_TIMER_E:`BIT_TIMER_A] == $past(reg_wdata[`BIT_TIMER_E:`BIT_TIMER_A]))
    else $error("timer bits not stored");
  a_mid_bits_kept: assert property (wr_hit |=>
    ctrl_q[`BIT_TWO_WIRE:`BIT_SYNC_A] == $past(reg_wdata[`BIT_TWO_WIRE:`BIT_SYNC_A]))
    else $error("serial group bits not stored");
  a_adc_bit_kept: assert property (wr_hit |=> ctrl_q[`BIT_ADC] == $past(reg_wdata[`BIT_ADC]))
    else $error("adc bit not stored");
  a_motor_bits_kept: assert property (wr_hit |=>
    ctrl_q[`BIT_ENCODER:`BIT_MOTOR_PWM] == ($past(reg_wdata[`BIT_ENCODER:`BIT_MOTOR_PWM]) & {2{HAS_MOTOR}}))
    else $error("motor bits stored wrongly for variant");
  a_can_bit_kept: assert property (wr_hit |=> ctrl_q[`BIT_CAN] == ($past(reg_wdata[`BIT_CAN]) && HAS_CAN))
    else $error("can bit stored wrongly for variant");
  a_rsvd_high: assert property (ctrl_q[`BIT_RSVD_HI] == 1'b0)
    else $error("upper unimplemented bit holds a one");
  a_rsvd_low: assert property (ctrl_q[`BIT_RSVD_LO] == 1'b0)
    else $error("lower unimplemented bit holds a one");
  a_foreign_write: assert property ((reg_wr && !wr_hit) |=> ctrl_q == $past(ctrl_q))
    else $error("unmapped write changed the register");
  a_hold_no_write: assert property (!wr_hit |=> $stable(ctrl_q))
    else $error("register changed without a write");
  a_read_idle: assert property (!rd_hit |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_motor_lines: assert property (HAS_MOTOR || (!encoder_iface_off && !motor_pwm_off))
    else $error("motor lines high without motor variant");
  a_can_variant: assert property (HAS_CAN || !can_ctrl_off)
    else $error("can line high without can variant");
  a_lines_cleared: assert property (@(posedge core_clk) $past(srst) |-> !any_off)
    else $error("disable line high after reset");

  // ----------------------------------------
  // Unimplemented positions
  // ----------------------------------------
  // Covers variant holes as well as the fixed gaps
  for (genvar b = 0; b < $bits(reg_word_t); b++) begin : g_rsvd
    if (!IMPL_MASK[b]) begin : g_chk
      a_rsvd_bit: assert property (@(posedge core_clk) disable iff (srst) ctrl_q[b] == 1'b0)
        else $error("unimplemented position holds a one");
    end
  end

  c_write: cover property (wr_hit && reg_wdata[15]);
  c_read_back: cover property (wr_hit ##1 rd_hit);
  c_all_off: cover property (ctrl_q == IMPL_MASK);
  c_foreign_write: cover property (reg_wr && !wr_hit);
  c_timer_read: cover property (rd_hit && ctrl_q[`BIT_TIMER_A]);
endmodule

/* rtl/periph_disable_map.svh */
`ifndef PERIPH_DISABLE_MAP_SVH
`define PERIPH_DISABLE_MAP_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PDC1_ADDR        4'h0
`define PDC1_RESET       16'h0000

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define BIT_TIMER_E      15
`define BIT_TIMER_D      14
`define BIT_TIMER_C      13
`define BIT_TIMER_B      12
`define BIT_TIMER_A      11
`define BIT_ENCODER      10
`define BIT_MOTOR_PWM    9
`define BIT_TWO_WIRE     7
`define BIT_SERIAL_B     6
`define BIT_SERIAL_A     5
`define BIT_SYNC_B       4
`define BIT_SYNC_A       3
`define BIT_CAN          1
`define BIT_ADC          0
// Positions that never store a one
`define BIT_RSVD_HI      8
`define BIT_RSVD_LO      2

// Always-present bits; bits 10, 9 and 1 depend on variant
`define BASE_MASK        16'hF8F9
`define MOTOR_MASK       16'h0600
`define CAN_MASK         16'h0002

`endif

/* rtl/periph_disable_pkg.sv */
package periph_disable_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [3:0]  reg_addr_t;
endpackage

/* rtl/disable_mask_reg.sv */
`timescale 1ns/1ns
`include "periph_disable_map.svh"

module disable_mask_reg
  import periph_disable_pkg::*;
#(
  parameter reg_word_t IMPL_MASK = `BASE_MASK
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  // Write port
  input  wire logic                          load,
  input  wire periph_disable_pkg::reg_word_t din,
  // Stored value
  output periph_disable_pkg::reg_word_t      q
);
  import periph_disable_pkg::*;

  reg_word_t q_next;

  // Unimplemented positions never take a write
  assign q_next = load ? (din & IMPL_MASK) : q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= `PDC1_RESET;
    end else begin
      q <= q_next;
    end
  end
endmodule

/* verification/peripheral_module_disable_test.sv */
`timescale 1ns/1ns
module peripheral_module_disable_test;
  import periph_disable_pkg::*;
  logic      core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg_addr_t reg_addr = 4'h0;
  reg_word_t reg_wdata = 16'h0000, m1 = 16'h0000, m2 = 16'h0000;
  reg_word_t reg_rdata, rdata2, offs;
  logic      timer_a_off, timer_b_off, timer_c_off, timer_d_off, timer_e_off, encoder_iface_off, motor_pwm_off;
  logic      two_wire_port_off, serial_port_b_off, serial_port_a_off, sync_serial_b_off, sync_serial_a_off;
  logic      can_ctrl_off, adc_off;
  logic [31:0] r;
  integer    seed = 32'h7D97, bad_count = 0, tests_run = 0;
  assign offs = {timer_e_off, timer_d_off, timer_c_off, timer_b_off, timer_a_off, encoder_iface_off, motor_pwm_off,
                 1'b0, two_wire_port_off, serial_port_b_off, serial_port_a_off, sync_serial_b_off,
                 sync_serial_a_off, 1'b0, can_ctrl_off, adc_off};
  always #25 core_clk = ~core_clk;
  peripheral_module_disable DUT (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_a_off, .timer_b_off, .timer_c_off, .timer_d_off, .timer_e_off, .encoder_iface_off, .motor_pwm_off,
    .two_wire_port_off, .serial_port_b_off, .serial_port_a_off, .sync_serial_b_off, .sync_serial_a_off,
    .can_ctrl_off, .adc_off);
  // Reduced variant: no motor pair, no CAN
  peripheral_module_disable #(.HAS_MOTOR(1'b0), .HAS_CAN(1'b0)) DUT2 (.core_clk, .srst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata(rdata2), .timer_a_off(), .timer_b_off(), .timer_c_off(), .timer_d_off(),
    .timer_e_off(), .encoder_iface_off(), .motor_pwm_off(), .two_wire_port_off(), .serial_port_b_off(),
    .serial_port_a_off(), .sync_serial_b_off(), .sync_serial_a_off(), .can_ctrl_off(), .adc_off());
  // ----------------------------------------
  // Bus tasks and compare
  // ----------------------------------------
  task automatic chk(input string nm, input reg_word_t seen, input reg_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input reg_addr_t a, input reg_word_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == 4'h0) begin
      m1 = d & 16'hFEFB;
      m2 = d & 16'hF8F9;
    end
    @(posedge core_clk);
    #1 chk("off lines", offs, m1);
  endtask
  task automatic rd(input reg_addr_t a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, (a == 4'h0) ? m1 : 16'h0000);
    chk("rdata variant", rdata2, (a == 4'h0) ? m2 : 16'h0000);
    @(posedge core_clk);
    #1 chk("rdata idle", reg_rdata, 16'h0000);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1 chk("reset lines", offs, 16'h0000);
    rd(4'h0);
    for (int i = 0; i < 16; i++) begin
      wr(4'h0, 16'h0001 << i);
      rd(4'h0);
    end
    wr(4'h0, 16'hFFFF);
    wr(4'h5, 16'h0000);
    rd(4'h5);
    rd(4'h0);
    for (int i = 0; i < 30; i++) begin
      r = $random(seed);
      wr(r[0] ? 4'h0 : r[7:4], r[31:16]);
      rd(4'h0);
    end
    // Second reset in mid-run must drop every line
    wr(4'h0, 16'hFFFF);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    m1 = 16'h0000;
    m2 = 16'h0000;
    #1 chk("re-reset lines", offs, 16'h0000);
    @(posedge core_clk);
    rd(4'h0);
    summarize();
  end
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule
